// file: hw/button_conditioner.sv
// Pushbutton synchroniser that classifies presses as brief or held and repeats while held.
`timescale 1ns/1ps
module button_conditioner #(
	parameter int HOLD_CYCLES = 12000000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic pinLevel,
	input wire logic [31:0] repeatCycles,
	output reading_logger_pkg::btn_evt_t evt
);
	import reading_logger_pkg::*;
	btn_state_t s_q, s_d;
	btn_evt_t e;

	if (HOLD_CYCLES < 2)
		$error("HOLD_CYCLES must be at least 2");

	always_comb
	begin
		s_d = s_q;
		e = '0;
		e.down = s_q.level;
		s_d.sync = {s_q.sync[1:0], pinLevel};
		// A level change counts only once the second and third stages agree.
		if (s_q.sync[1] == s_q.sync[2] && s_q.sync[2] != s_q.level)
		begin
			s_d.level = s_q.sync[2];
			s_d.cnt = '0;
			if (s_q.sync[2])
			begin
				e.press = 1'b1;
				s_d.held = 1'b0;
			end
			else if (s_q.held)
				e.heldRel = 1'b1;
			else
				e.briefRel = 1'b1;
		end
		else if (s_q.level)
		begin
			s_d.cnt = s_q.cnt + 32'h1;
			if (!s_q.held && s_q.cnt == 32'(HOLD_CYCLES - 1))
			begin
				s_d.held = 1'b1;
				s_d.cnt = '0;
				e.heldTick = 1'b1;
			end
			else if (s_q.held && s_q.cnt >= repeatCycles - 32'h1)
			begin
				s_d.cnt = '0;
				e.heldTick = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign evt = e;
endmodule

// file: hw/reading_logger_minmax.sv
// Reading logger with peak and trough tracking, two pushbuttons, display feed and APB status.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "reading_logger_params.svh"
// Operation
// - The logger holds up to 100 stored readings plus the peak and trough seen while active.
// - A full buffer leaves the logger active and peak and trough still update.
// - Only a store/clear press or power-on reset deactivates the logger, turning the logging indicator off.
// - The storage rate code is 0 (every reading), 1 (1 s), 2 (10 s), 3 (1 min), 4 (10 min) or 5 (1 h).
// - Peak and trough sample the reading three times per second whatever the rate.
// - Holding store/clear cycles the shown rate code; release latches it and starts storing at that rate.
// - A brief store/clear press starts the logger without a rate, tracking only peak and trough.
// - A store/clear press while logging stops at once, keeping stored data and extremes for recall.
// - The recall indicator flashes once 100 readings are stored, and recall is allowed at any time.
// - Recall shows first the newest stored reading, then the peak, then the trough.
// - Holding recall steps through items automatically, faster the longer it is held.
// - Each brief recall press after the one that opens recall advances the recall pointer by one item and shows that item.
// - Stored data stays unchanged after stopping and is cleared only when a new cycle starts, whether it stores or tracks extremes only.
module reading_logger_minmax #(
	parameter int DEPTH = `LOG_DEPTH,
	parameter int THIRD_CYCLES = `CLK_HZ / `SAMPLES_PER_SEC,
	parameter int HOLD_CYCLES = `CLK_HZ / 1000 * `HOLD_MS,
	parameter int SCROLL_CYCLES = `CLK_HZ / 1000 * `SCROLL_MS,
	parameter int RECALL_SLOW_CYCLES = `CLK_HZ / 1000 * `RECALL_SLOW_MS,
	parameter int RECALL_FAST_CYCLES = `CLK_HZ / 1000 * `RECALL_FAST_MS
) (
	input wire logic clk,
	input wire logic rst,
	input reading_logger_pkg::apb_req_t apbReq,
	output reading_logger_pkg::apb_rsp_t apbRsp,
	input wire logic storeClearButton,
	input wire logic recallButton,
	input wire logic [`READING_W-1:0] reading,
	input wire logic readingValid,
	output logic loggingIndicator,
	output logic recallIndicator,
	output logic [`READING_W-1:0] displayValue,
	output reading_logger_pkg::disp_kind_t displayKind,
	output logic irq
);
	import reading_logger_pkg::*;
	localparam int W = `READING_W;
	log_state_t s_q, s_d;
	logic [W-1:0] mem [DEPTH];
	btn_evt_t scEvt, rcEvt;
	logic [31:0] recallRepeat;
	logic thirdTick, secTick, periodTick, storeTick, storeEn, startNow;
	logic [W-1:0] storeVal;
	logic [6:0] itemCount, memIdx;
	logic [`EV_N-1:0] ev, clr;

	if (DEPTH < 1 || DEPTH > 125)
		$error("DEPTH must lie between 1 and 125");
	if (THIRD_CYCLES < 2 || SCROLL_CYCLES < 2 || RECALL_FAST_CYCLES < 2 || RECALL_SLOW_CYCLES < 2)
		$error("Timing counts must be at least 2");

	// Recall repeats start slow and speed up after a few automatic steps.
	assign recallRepeat = (s_q.recallSteps < 4'(`RECALL_SPEEDUP)) ? 32'(RECALL_SLOW_CYCLES) :
		32'(RECALL_FAST_CYCLES);

	button_conditioner #(.HOLD_CYCLES(HOLD_CYCLES)) scButton (
		.clk(clk),
		.rst(rst),
		.pinLevel(storeClearButton),
		.repeatCycles(32'(SCROLL_CYCLES)),
		.evt(scEvt)
	);

	button_conditioner #(.HOLD_CYCLES(HOLD_CYCLES)) rcButton (
		.clk(clk),
		.rst(rst),
		.pinLevel(recallButton),
		.repeatCycles(recallRepeat),
		.evt(rcEvt)
	);

	// With no entries the sequence still offers an empty slot, the peak and the trough.
	assign itemCount = (s_q.count == 7'h0) ? 7'h3 : s_q.count + 7'h2;
	assign memIdx = (s_q.recallPos == 7'h0) ? s_q.count - 7'h1 : s_q.count - s_q.recallPos + 7'h1;

	always_comb
	begin
		s_d = s_q;
		ev = '0;
		clr = '0;
		storeEn = 1'b0;
		startNow = 1'b0;
		secTick = 1'b0;
		periodTick = 1'b0;
		thirdTick = (s_q.thirdCnt == 32'(THIRD_CYCLES - 1));
		storeVal = (s_q.rate == 3'h0) ? reading : s_q.last;
		if (readingValid)
		begin
			s_d.last = reading;
			s_d.lastValid = 1'b1;
		end
		s_d.thirdCnt = thirdTick ? '0 : s_q.thirdCnt + 32'h1;
		if (thirdTick)
		begin
			s_d.blink = ~s_q.blink;
			s_d.thirds = (s_q.thirds == 2'h2) ? 2'h0 : s_q.thirds + 2'h1;
			secTick = (s_q.thirds == 2'h2);
		end
		if (secTick)
		begin
			periodTick = (s_q.secCnt == ratePeriod(s_q.rate) - 12'h1);
			s_d.secCnt = periodTick ? 12'h0 : s_q.secCnt + 12'h1;
		end
		storeTick = (s_q.rate == 3'h0) ? readingValid : periodTick;

		case (s_q.mode)
			MODE_IDLE:
			begin
				if (scEvt.press)
				begin
					s_d.mode = MODE_SELECT;
					s_d.rate = 3'h0;
					s_d.rateShown = 1'b0;
				end
			end
			MODE_SELECT:
			begin
				if (scEvt.heldTick)
				begin
					s_d.rateShown = 1'b1;
					if (s_q.rateShown)
						s_d.rate = (s_q.rate == 3'(`RATE_N - 1)) ? 3'h0 : s_q.rate + 3'h1;
				end
				if (scEvt.briefRel || scEvt.heldRel)
				begin
					startNow = 1'b1;
					s_d.storing = scEvt.heldRel;
				end
			end
			MODE_LOG:
			begin
				if (scEvt.press)
				begin
					s_d.mode = MODE_RELEASE;
					ev[`EV_STOP] = 1'b1;
				end
				else
				begin
					storeEn = s_q.storing && storeTick && s_q.count < 7'(DEPTH);
					if (storeEn)
					begin
						s_d.count = s_q.count + 7'h1;
						ev[`EV_STORE] = 1'b1;
						ev[`EV_FULL] = (s_q.count == 7'(DEPTH - 1));
					end
					// Extremes keep updating when the buffer is full.
					if (thirdTick && s_q.lastValid)
					begin
						s_d.haveExtremes = 1'b1;
						if (!s_q.haveExtremes || $signed(s_q.last) > $signed(s_q.peak))
							s_d.peak = s_q.last;
						if (!s_q.haveExtremes || $signed(s_q.last) < $signed(s_q.trough))
							s_d.trough = s_q.last;
					end
				end
			end
			MODE_RELEASE:
			begin
				// The release that ends a stop press must not restart the logger.
				if (!scEvt.down)
					s_d.mode = MODE_IDLE;
			end
			default:
				s_d.mode = MODE_IDLE;
		endcase

		if (startNow)
		begin
			s_d.mode = MODE_LOG;
			s_d.count = 7'h0;
			s_d.haveExtremes = 1'b0;
			s_d.peak = '0;
			s_d.trough = '0;
			s_d.secCnt = 12'h0;
			s_d.recallOn = 1'b0;
			s_d.recallPos = 7'h0;
			ev[`EV_START] = 1'b1;
		end
		else if (rcEvt.press)
		begin
			s_d.recallSteps = 4'h0;
			if (!s_q.recallOn)
			begin
				s_d.recallOn = 1'b1;
				s_d.recallEnter = 1'b1;
				s_d.recallPos = 7'h0;
			end
		end
		else if (s_q.recallOn && (rcEvt.heldTick || (rcEvt.briefRel && !s_q.recallEnter)))
		begin
			s_d.recallPos = (s_q.recallPos + 7'h1 >= itemCount) ? 7'h0 : s_q.recallPos + 7'h1;
			s_d.recallEnter = 1'b0;
			if (rcEvt.heldTick && s_q.recallSteps != 4'hF)
				s_d.recallSteps = s_q.recallSteps + 4'h1;
		end
		else if (rcEvt.briefRel)
			s_d.recallEnter = 1'b0;

		if (s_q.mode == MODE_SELECT && s_q.rateShown)
		begin
			s_d.dispKind = KIND_RATE;
			s_d.dispValue = W'(s_q.rate);
		end
		else if (s_q.recallOn)
		begin
			case (s_q.recallPos)
				7'h1: s_d.dispKind = KIND_PEAK;
				7'h2: s_d.dispKind = KIND_TROUGH;
				default: s_d.dispKind = (s_q.count == 7'h0) ? KIND_EMPTY : KIND_STORED;
			endcase
			case (s_q.recallPos)
				7'h1: s_d.dispValue = s_q.peak;
				7'h2: s_d.dispValue = s_q.trough;
				default: s_d.dispValue = (s_q.count == 7'h0) ? '0 : mem[memIdx];
			endcase
		end
		else
		begin
			s_d.dispKind = KIND_LIVE;
			s_d.dispValue = s_q.last;
		end

		s_d.prdata = 32'h0;
		s_d.pslverr = 1'b0;
		if (apbReq.psel && !apbReq.penable)
		begin
			case (apbReq.paddr)
				`OFF_STATE: s_d.prdata = {9'h0, s_q.recallPos, 1'b0, s_q.count, 1'b0, s_q.rate,
					s_q.recallOn, s_q.count == 7'(DEPTH), s_q.storing, s_q.mode == MODE_LOG};
				`OFF_PEAK: s_d.prdata = {{(32 - W){s_q.peak[W-1]}}, s_q.peak};
				`OFF_TROUGH: s_d.prdata = {{(32 - W){s_q.trough[W-1]}}, s_q.trough};
				`OFF_LAST: s_d.prdata = {{(32 - W){s_q.last[W-1]}}, s_q.last};
				`OFF_IRQ_STATUS: s_d.prdata = 32'(s_q.irqStatus);
				`OFF_IRQ_ENABLE: s_d.prdata = 32'(s_q.irqEnable);
				`OFF_IRQ_CLEAR: s_d.prdata = 32'h0;
				default: s_d.pslverr = 1'b1;
			endcase
		end
		else if (apbReq.psel)
		begin
			s_d.prdata = s_q.prdata;
			s_d.pslverr = s_q.pslverr;
			if (apbReq.pwrite && apbReq.paddr == `OFF_IRQ_ENABLE)
				s_d.irqEnable = apbReq.pwdata[`EV_N-1:0];
			if (apbReq.pwrite && apbReq.paddr == `OFF_IRQ_CLEAR)
				clr = apbReq.pwdata[`EV_N-1:0];
		end
		// A new event in the clearing cycle survives the clear.
		s_d.irqStatus = (s_q.irqStatus & ~clr) | ev;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.irqEnable <= `IRQ_ENABLE_RST;
		end
		else
			s_q <= s_d;
	end

	// The buffer keeps no reset so its contents survive until a new cycle overwrites them.
	always_ff @(posedge clk)
	begin
		if (storeEn)
			mem[s_q.count] <= storeVal;
	end

	assign apbRsp.pready = 1'b1;
	assign apbRsp.prdata = s_q.prdata;
	assign apbRsp.pslverr = s_q.pslverr;
	assign loggingIndicator = (s_q.mode == MODE_LOG);
	assign recallIndicator = (s_q.count == 7'(DEPTH)) ? s_q.blink : s_q.recallOn;
	assign displayValue = s_q.dispValue;
	assign displayKind = s_q.dispKind;
	assign irq = |(s_q.irqStatus & s_q.irqEnable);

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	count_cap_a: assert property (s_q.count <= 7'(DEPTH))
		else $error("Stored count exceeds the buffer depth");
	stays_active_a: assert property (loggingIndicator && !scEvt.press |=> loggingIndicator)
		else $error("Logger left the active state without a button press");
	only_button_a: assert property ($fell(loggingIndicator) |-> $past(scEvt.press))
		else $error("Logging indicator fell without a store/clear press");
	rate_code_a: assert property (s_q.rate < 3'(`RATE_N))
		else $error("Rate code out of range");
	extremes_pace_a: assert property ($changed(s_q.peak) || $changed(s_q.trough) |->
		$past(thirdTick) || $past(startNow))
		else $error("Extremes changed off the sampling tick");
	latch_rate_a: assert property (s_q.mode == MODE_SELECT && scEvt.heldRel |=>
		loggingIndicator && s_q.storing && s_q.rate == $past(s_q.rate))
		else $error("Held release did not latch the shown rate");
	brief_start_a: assert property (s_q.mode == MODE_SELECT && scEvt.briefRel |=>
		loggingIndicator && !s_q.storing && s_q.count == 7'h0)
		else $error("Brief press did not start an extremes-only cycle");
	stop_keeps_a: assert property (loggingIndicator && scEvt.press |=>
		!loggingIndicator && $stable(s_q.count) && $stable(s_q.peak))
		else $error("Stop press did not stop at once keeping data");
	recall_first_a: assert property (rcEvt.press && !s_q.recallOn && !startNow && s_q.count != 7'h0 |=>
		##1 s_q.dispKind == KIND_STORED && s_q.dispValue == mem[s_q.count - 7'h1])
		else $error("Recall did not open on the newest stored reading");
	count_frozen_a: assert property (!loggingIndicator && !startNow |=> $stable(s_q.count))
		else $error("Buffer count changed while stopped");
	full_drop_a: assert property (s_q.count == 7'(DEPTH) |-> !storeEn)
		else $error("Store attempted into a full buffer");
	step_source_a: assert property (s_q.recallOn && $changed(s_q.recallPos) |->
		$past(rcEvt.heldTick) || $past(rcEvt.briefRel) || $past(rcEvt.press))
		else $error("Recall pointer moved without a recall button event");

	rate_latched_c: cover property (s_q.mode == MODE_SELECT && scEvt.heldRel && s_q.rate == 3'h2);
	buffer_fills_c: cover property (storeEn && s_q.count == 7'(DEPTH - 1));
	fast_scroll_c: cover property (rcEvt.heldTick && s_q.recallSteps >= 4'(`RECALL_SPEEDUP));
	stop_press_c: cover property (loggingIndicator && scEvt.press);
endmodule

// file: inc/reading_logger_params.svh
// Constants of the reading logger: layout, offsets, reset values and timing.
`ifndef READING_LOGGER_PARAMS_SVH
`define READING_LOGGER_PARAMS_SVH
`define READING_W 20
`define LOG_DEPTH 100
`define RATE_N 6
`define RATE1_SEC 1
`define RATE2_SEC 10
`define RATE3_SEC 60
`define RATE4_SEC 600
`define RATE5_SEC 3600
`define CLK_HZ 20000000
`define SAMPLES_PER_SEC 3
`define HOLD_MS 600
`define SCROLL_MS 1000
`define RECALL_SLOW_MS 400
`define RECALL_FAST_MS 80
`define RECALL_SPEEDUP 8
`define OFF_STATE 12'h000
`define OFF_PEAK 12'h004
`define OFF_TROUGH 12'h008
`define OFF_LAST 12'h00C
`define OFF_IRQ_STATUS 12'h010
`define OFF_IRQ_ENABLE 12'h014
`define OFF_IRQ_CLEAR 12'h018
`define EV_START 0
`define EV_STOP 1
`define EV_FULL 2
`define EV_STORE 3
`define EV_N 4
`define IRQ_ENABLE_RST 4'h0
`endif

// file: inc/reading_logger_pkg.sv
// Types shared by the reading logger and its button conditioner.
`include "reading_logger_params.svh"
package reading_logger_pkg;
	typedef enum logic [1:0] {MODE_IDLE, MODE_SELECT, MODE_LOG, MODE_RELEASE} mode_t;
	typedef enum logic [2:0] {KIND_LIVE, KIND_RATE, KIND_STORED, KIND_PEAK, KIND_TROUGH, KIND_EMPTY} disp_kind_t;
	typedef struct packed {logic psel; logic penable; logic pwrite; logic [11:0] paddr; logic [31:0] pwdata;} apb_req_t;
	typedef struct packed {logic pready; logic [31:0] prdata; logic pslverr;} apb_rsp_t;
	typedef struct packed {logic down; logic press; logic briefRel; logic heldRel; logic heldTick;} btn_evt_t;
	typedef struct packed {logic [2:0] sync; logic level; logic held; logic [31:0] cnt;} btn_state_t;
	typedef struct packed {
		mode_t mode;
		logic [2:0] rate;
		logic rateShown;
		logic storing;
		logic [6:0] count;
		logic [6:0] recallPos;
		logic recallOn;
		logic recallEnter;
		logic [3:0] recallSteps;
		logic [`READING_W-1:0] last;
		logic lastValid;
		logic [`READING_W-1:0] peak;
		logic [`READING_W-1:0] trough;
		logic haveExtremes;
		logic [31:0] thirdCnt;
		logic [1:0] thirds;
		logic [11:0] secCnt;
		logic blink;
		logic [`READING_W-1:0] dispValue;
		disp_kind_t dispKind;
		logic [`EV_N-1:0] irqStatus;
		logic [`EV_N-1:0] irqEnable;
		logic [31:0] prdata;
		logic pslverr;
	} log_state_t;
	function automatic logic [11:0] ratePeriod(input logic [2:0] code);
		case (code)
			3'h1: ratePeriod = 12'(`RATE1_SEC);
			3'h2: ratePeriod = 12'(`RATE2_SEC);
			3'h3: ratePeriod = 12'(`RATE3_SEC);
			3'h4: ratePeriod = 12'(`RATE4_SEC);
			default: ratePeriod = 12'(`RATE5_SEC);
		endcase
	endfunction
endpackage

// file: tb/front_end_model.sv
// Measurement front end model that feeds periodic readings to the logger.
`timescale 1ns/1ps
`include "reading_logger_params.svh"
module front_end_model #(
	parameter int PERIOD = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`READING_W-1:0] level,
	output logic [`READING_W-1:0] reading,
	output logic readingValid
);
	int cnt;
	// Between strobes the bus shows the inverse, so a stale sample can never pass for valid data.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 0;
			readingValid <= 1'b0;
			reading <= '0;
		end
		else
		begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			readingValid <= (cnt == PERIOD - 1);
			reading <= (cnt == PERIOD - 1) ? level : ~level;
		end
	end
endmodule

// file: tb/test_reading_logger_minmax.sv
// Self-checking bench for the reading logger with peak and trough tracking.
`timescale 1ns/1ps
`include "reading_logger_params.svh"
module test_reading_logger_minmax;
	import reading_logger_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	apb_req_t apbReq = '0;
	apb_rsp_t apbRsp;
	logic storeClearButton = 1'b0;
	logic recallButton = 1'b0;
	logic [`READING_W-1:0] level = 20'h00000;
	logic [`READING_W-1:0] reading;
	logic [`READING_W-1:0] displayValue;
	logic readingValid, loggingIndicator, recallIndicator, irq, err;
	disp_kind_t displayKind;
	logic [31:0] rd;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	front_end_model fe (.clk(clk), .rst(rst), .level(level), .reading(reading), .readingValid(readingValid));
	// The buffer keeps its real depth; only the timing counts are shortened, so the fill path runs at full size.
	reading_logger_minmax #(.THIRD_CYCLES(30), .HOLD_CYCLES(20), .SCROLL_CYCLES(10),
		.RECALL_SLOW_CYCLES(8), .RECALL_FAST_CYCLES(3)) dut (.clk(clk), .rst(rst), .apbReq(apbReq),
		.apbRsp(apbRsp), .storeClearButton(storeClearButton), .recallButton(recallButton), .reading(reading),
		.readingValid(readingValid), .loggingIndicator(loggingIndicator), .recallIndicator(recallIndicator),
		.displayValue(displayValue), .displayKind(displayKind), .irq(irq));
	task automatic check(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1)
		begin
			num_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_cycles(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		apbReq.psel <= 1'b1;
		apbReq.pwrite <= wr;
		apbReq.paddr <= addr;
		apbReq.pwdata <= data;
		@(posedge clk);
		apbReq.penable <= 1'b1;
		do
			@(posedge clk);
		while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		// An idle edge keeps a following call from raising psel in the time step that lowered it.
		@(posedge clk);
	endtask
	// Pins are synchronised inside, so a press is only judged eight edges after release.
	task automatic press(input logic which, input int len);
		if (which)
			recallButton <= 1'b1;
		else
			storeClearButton <= 1'b1;
		wait_cycles(len);
		recallButton <= 1'b0;
		storeClearButton <= 1'b0;
		wait_cycles(8);
	endtask
	task automatic reset_values();
		check(loggingIndicator === 1'b0 && irq === 1'b0, "idle outputs");
		apb(1'b0, `OFF_STATE, 32'h0);
		check(rd === 32'h0 && err === 1'b0, "state after reset");
		apb(1'b0, `OFF_IRQ_ENABLE, 32'h0);
		check(rd === {28'h0000000, `IRQ_ENABLE_RST}, "irq enable reset value");
		apb(1'b1, 12'h01C, 32'hFFFFFFFF);
		check(err === 1'b1 && rd === 32'h0, "unmapped access error");
	endtask
	task automatic brief_start();
		press(1'b0, 5);
		check(loggingIndicator === 1'b1, "brief press starts");
		apb(1'b0, `OFF_STATE, 32'h0);
		check(rd[1:0] === 2'b01, "extremes only mode");
		press(1'b0, 5);
		check(loggingIndicator === 1'b0, "press stops logger");
	endtask
	task automatic irq_flow();
		apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
		check(rd[1:0] === 2'b11 && irq === 1'b0, "events latched but masked");
		apb(1'b1, `OFF_IRQ_ENABLE, 32'h3);
		wait_cycles(1);
		check(irq === 1'b1, "irq raised when enabled");
		apb(1'b1, `OFF_IRQ_CLEAR, 32'hF);
		wait_cycles(1);
		apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
		check(rd[3:0] === 4'h0 && irq === 1'b0, "status cleared");
	endtask
	task automatic held_log();
		logic b;
		int n;
		level <= 20'h00005;
		press(1'b0, 26);
		apb(1'b0, `OFF_STATE, 32'h0);
		check(rd[1:0] === 2'b11 && rd[6:4] === 3'h0, "rate zero logging");
		// One store every eight cycles fills all entries before the level moves.
		wait_cycles(820);
		level <= 20'hFFFFD;
		wait_cycles(70);
		level <= 20'h00002;
		wait_cycles(70);
		apb(1'b0, `OFF_STATE, 32'h0);
		check(rd[14:8] === 7'(`LOG_DEPTH) && rd[2] === 1'b1 && rd[0] === 1'b1, "full and active");
		b = recallIndicator;
		n = 0;
		while (recallIndicator === b && n < 80)
		begin
			@(posedge clk);
			n++;
		end
		check(n < 80, "recall indicator flashes");
		apb(1'b0, `OFF_PEAK, 32'h0);
		check(rd === 32'h00000005, "peak value");
		apb(1'b0, `OFF_TROUGH, 32'h0);
		check(rd === 32'hFFFFFFFD, "trough after full");
		press(1'b0, 5);
		check(loggingIndicator === 1'b0, "stop at once");
		level <= 20'h00009;
		wait_cycles(70);
		apb(1'b0, `OFF_PEAK, 32'h0);
		check(rd === 32'h00000005, "peak kept after stop");
	endtask
	task automatic recall_walk();
		press(1'b1, 5);
		check(displayKind === KIND_STORED && displayValue === 20'h00005, "newest first");
		press(1'b1, 5);
		check(displayKind === KIND_PEAK && displayValue === 20'h00005, "peak second");
		press(1'b1, 5);
		check(displayKind === KIND_TROUGH && displayValue === 20'hFFFFD, "trough third");
		press(1'b1, 5);
		check(displayKind === KIND_STORED && displayValue === 20'h00005, "older entry next");
		// Every stored entry holds the same value, so the pointer is read back instead of the display.
		// Slow steps alone would reach position 13; anything from 16 on needs the faster pace.
		recallButton <= 1'b1;
		wait_cycles(100);
		recallButton <= 1'b0;
		wait_cycles(8);
		apb(1'b0, `OFF_STATE, 32'h0);
		check(rd[22:16] >= 7'h10, "held recall steps and speeds up");
	endtask
	task automatic rate_one();
		press(1'b0, 36);
		apb(1'b0, `OFF_STATE, 32'h0);
		check(rd[6:4] === 3'h1 && rd[1] === 1'b1, "rate one latched");
		wait_cycles(200);
		apb(1'b0, `OFF_STATE, 32'h0);
		check(rd[14:8] === 7'h02 || rd[14:8] === 7'h03, "one store per second");
	endtask
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors++;
			conclude();
		end
	end
	initial
	begin
		wait_cycles(5);
		rst <= 1'b0;
		wait_cycles(1);
		reset_values();
		brief_start();
		irq_flow();
		held_log();
		recall_walk();
		rate_one();
		conclude();
	end
endmodule
